/* design/bdm_move_unit.sv */
// Bit and digit move unit: a 32-word data area with single-bit copy,
// nibble copy and bit-run transfer, reached over AHB-Lite.
// Assumes one slave on the bus (hreadyout is the bus hready) and
// word-sized aligned accesses only.
//
// Function
// - Single-bit move copies selected source bit into selected destination bit.
// - Single-bit fault when either control byte exceeds 0F, else cleared.
// - Single-bit move leaves all other destination bits unchanged.
// - Single-bit move works when source and destination are one word.
// - Control 0C05 copies source bit 5 to destination bit 12.
// - Digit move sees each word as four nibbles, digit 0 lowest.
// - Source digits read ascending, wrapping digit 3 back to 0.
// - Destination digits written ascending, wrapping digit 3 back to 0.
// - Digit fault when any of three low nibbles exceeds 3, else cleared.
// - Control 31 copies four digits, source digit 1 to destination digit 0.
// - Bit run copies up to 255 consecutive bits across word boundaries.
// - Bit count zero modifies no destination bit.
// - Bit run keeps every destination bit outside the run.
// - Bit run is correct when overlapping source and destination ranges do not wrap past word 31.
`timescale 1ns/1ps
`default_nettype none

module bdm_move_unit (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic irq_out,
    output logic fault_indicator_out,
    output logic busy_out
);

    // ==================================================================
    // Reset release
    logic rst_meta_reg;
    logic rst_n_reg;

    // Asynchronous assert, two-stage synchronous release
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ==================================================================
    // Declarations
    logic dp_wr_reg, dp_wr_next;
    logic dp_rd_reg, dp_rd_next;
    logic [11:0] dp_addr_reg, dp_addr_next;
    logic hready_reg, hready_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ap_valid;

    logic [15:0] mem_reg [bdm_pkg::DATA_WORDS];
    logic [15:0] mem_next [bdm_pkg::DATA_WORDS];
    logic [15:0] cw_reg, cw_next;
    logic [4:0] src_idx_reg, src_idx_next;
    logic [4:0] dst_idx_reg, dst_idx_next;
    logic [2:0] op_pend_reg, op_pend_next;
    bdm_pkg::bdm_state_type state_reg, state_next;
    logic fault_reg, fault_next;
    logic [7:0] run_left_reg, run_left_next;
    logic [7:0] run_k_reg, run_k_next;
    logic run_down_reg, run_down_next;
    logic [1:0] irq_sts_reg, irq_sts_next;
    logic [1:0] irq_mask_reg, irq_mask_next;
    logic irq_reg;
    logic busy;
    logic ev_done;
    logic ev_fault;

    logic single_bit_move_edge;
    logic nibble_move_edge;
    logic bit_run_transfer_edge;
    logic [15:0] op_result;
    logic op_error;
    logic [9:0] src_glob;
    logic [9:0] dst_glob;
    logic [9:0] src_pos;
    logic [9:0] dst_pos;
    logic data_hit;
    logic [4:0] data_idx;

    // ==================================================================
    // AHB-Lite slave front end
    assign ap_valid = hsel_in && htrans_in[1] && hready_in;
    assign data_hit = (dp_addr_reg[11:7] == bdm_pkg::DATA_PAGE);
    assign data_idx = dp_addr_reg[6:2];
    assign busy = (state_reg != bdm_pkg::ST_IDLE) || (op_pend_reg != 3'h0);

    // Reads take one wait state so that hrdata comes from a flip-flop
    // and always reflects any write in the preceding data phase
    always_comb begin
        dp_wr_next = ap_valid && hwrite_in;
        dp_rd_next = ap_valid && !hwrite_in;
        dp_addr_next = ap_valid ? haddr_in[11:0] : dp_addr_reg;
        hready_next = !(ap_valid && !hwrite_in);
        rdata_next = rdata_reg;
        if (dp_rd_reg && !hready_reg) begin
            rdata_next = 32'h0000_0000;
            if (data_hit) begin
                rdata_next[15:0] = mem_reg[data_idx];
            end else begin
                case (dp_addr_reg)
                    bdm_pkg::OFS_CW: rdata_next[15:0] = cw_reg;
                    bdm_pkg::OFS_SRC: rdata_next[4:0] = src_idx_reg;
                    bdm_pkg::OFS_DST: rdata_next[4:0] = dst_idx_reg;
                    bdm_pkg::OFS_STATUS: begin
                        rdata_next[bdm_pkg::STS_FAULT_BIT] = fault_reg;
                        rdata_next[bdm_pkg::STS_BUSY_BIT] = busy;
                    end
                    bdm_pkg::OFS_IRQ_STS: rdata_next[1:0] = irq_sts_reg;
                    bdm_pkg::OFS_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    // Bus pipeline registers
    always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            dp_wr_reg <= 1'b0;
            dp_rd_reg <= 1'b0;
            dp_addr_reg <= 12'h000;
            hready_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            dp_wr_reg <= dp_wr_next;
            dp_rd_reg <= dp_rd_next;
            dp_addr_reg <= dp_addr_next;
            hready_reg <= hready_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==================================================================
    // Word operations
    bdm_word_ops u_word_ops (
        .src_word_in(mem_reg[src_idx_reg]),
        .dst_word_in(mem_reg[dst_idx_reg]),
        .ctrl_word_in(cw_reg),
        .nibble_mode_in(nibble_move_edge),
        .result_out(op_result),
        .error_out(op_error)
    );

    // One-cycle enables taken from the pending command, single bit first
    assign single_bit_move_edge = (state_reg == bdm_pkg::ST_IDLE) && op_pend_reg[bdm_pkg::CTRL_SINGLE_BIT];
    assign nibble_move_edge = (state_reg == bdm_pkg::ST_IDLE) && !op_pend_reg[bdm_pkg::CTRL_SINGLE_BIT] &&
                              op_pend_reg[bdm_pkg::CTRL_NIBBLE_BIT];
    assign bit_run_transfer_edge = (state_reg == bdm_pkg::ST_IDLE) &&
                                   (op_pend_reg[1:0] == 2'b00) && op_pend_reg[bdm_pkg::CTRL_RUN_BIT];

    // Global bit positions: word index times 16 plus bit
    assign src_glob = {1'b0, src_idx_reg, cw_reg[3:0]};
    assign dst_glob = {1'b0, dst_idx_reg, cw_reg[7:4]};
    assign src_pos = 10'(src_glob + {2'b00, run_k_reg});
    assign dst_pos = 10'(dst_glob + {2'b00, run_k_reg});

    // ==================================================================
    // Execution and data area next state
    always_comb begin
        mem_next = mem_reg;
        cw_next = cw_reg;
        src_idx_next = src_idx_reg;
        dst_idx_next = dst_idx_reg;
        op_pend_next = op_pend_reg;
        state_next = state_reg;
        fault_next = fault_reg;
        run_left_next = run_left_reg;
        run_k_next = run_k_reg;
        run_down_next = run_down_reg;
        ev_done = 1'b0;
        ev_fault = 1'b0;

        // Operand writes are ignored while an operation is under way
        if (dp_wr_reg && !busy) begin
            if (data_hit) begin
                mem_next[data_idx] = hwdata_in[15:0];
            end else begin
                case (dp_addr_reg)
                    bdm_pkg::OFS_CTRL: op_pend_next = hwdata_in[2:0];
                    bdm_pkg::OFS_CW: cw_next = hwdata_in[15:0];
                    bdm_pkg::OFS_SRC: src_idx_next = hwdata_in[4:0];
                    bdm_pkg::OFS_DST: dst_idx_next = hwdata_in[4:0];
                    default: ;
                endcase
            end
        end

        case (state_reg)
            bdm_pkg::ST_IDLE: begin
                // Nothing moves unless an enable is raised
                if (single_bit_move_edge || nibble_move_edge) begin
                    mem_next[dst_idx_reg] = op_result;
                    fault_next = op_error;
                    ev_fault = op_error;
                    ev_done = 1'b1;
                    op_pend_next = 3'h0;
                end else if (bit_run_transfer_edge) begin
                    fault_next = 1'b0;
                    op_pend_next = 3'h0;
                    run_left_next = cw_reg[15:8];
                    // Copy from the top end when the target lies above the source
                    run_down_next = (dst_glob > src_glob);
                    run_k_next = (dst_glob > src_glob) ? 8'(cw_reg[15:8] - 8'h01) : 8'h00;
                    if (cw_reg[15:8] == 8'h00) begin
                        ev_done = 1'b1;
                    end else begin
                        state_next = bdm_pkg::ST_RUN;
                    end
                end
            end
            bdm_pkg::ST_RUN: begin
                // One bit per cycle; indices wrap inside the data area
                mem_next[dst_pos[8:4]][dst_pos[3:0]] = mem_reg[src_pos[8:4]][src_pos[3:0]];
                run_left_next = 8'(run_left_reg - 8'h01);
                run_k_next = run_down_reg ? 8'(run_k_reg - 8'h01) : 8'(run_k_reg + 8'h01);
                if (run_left_reg == 8'h01) begin
                    state_next = bdm_pkg::ST_IDLE;
                    ev_done = 1'b1;
                end
            end
            default: state_next = bdm_pkg::ST_IDLE;
        endcase
    end

    // Data area and sequencer registers
    always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            for (int i = 0; i < bdm_pkg::DATA_WORDS; i++) begin
                mem_reg[i] <= bdm_pkg::WORD_RESET;
            end
            cw_reg <= bdm_pkg::CW_RESET;
            src_idx_reg <= bdm_pkg::IDX_RESET;
            dst_idx_reg <= bdm_pkg::IDX_RESET;
            op_pend_reg <= 3'h0;
            state_reg <= bdm_pkg::ST_IDLE;
            fault_reg <= 1'b0;
            run_left_reg <= 8'h00;
            run_k_reg <= 8'h00;
            run_down_reg <= 1'b0;
        end else begin
            mem_reg <= mem_next;
            cw_reg <= cw_next;
            src_idx_reg <= src_idx_next;
            dst_idx_reg <= dst_idx_next;
            op_pend_reg <= op_pend_next;
            state_reg <= state_next;
            fault_reg <= fault_next;
            run_left_reg <= run_left_next;
            run_k_reg <= run_k_next;
            run_down_reg <= run_down_next;
        end
    end

    // ==================================================================
    // Interrupt status and mask
    // A new event in the same cycle as a write-one clear keeps its bit
    always_comb begin
        irq_sts_next = irq_sts_reg;
        irq_mask_next = irq_mask_reg;
        if (dp_wr_reg && (dp_addr_reg == bdm_pkg::OFS_IRQ_STS)) begin
            irq_sts_next = irq_sts_reg & ~hwdata_in[1:0];
        end
        if (dp_wr_reg && (dp_addr_reg == bdm_pkg::OFS_IRQ_MASK)) begin
            irq_mask_next = hwdata_in[1:0];
        end
        irq_sts_next[bdm_pkg::IRQ_DONE_BIT] = irq_sts_next[bdm_pkg::IRQ_DONE_BIT] | ev_done;
        irq_sts_next[bdm_pkg::IRQ_FAULT_BIT] = irq_sts_next[bdm_pkg::IRQ_FAULT_BIT] | ev_fault;
    end

    // Interrupt registers; the line follows status one cycle later
    always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            irq_sts_reg <= bdm_pkg::IRQ_RESET;
            irq_mask_reg <= bdm_pkg::IRQ_RESET;
            irq_reg <= 1'b0;
        end else begin
            irq_sts_reg <= irq_sts_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= |(irq_sts_reg & irq_mask_reg);
        end
    end

    // ==================================================================
    // Outputs from flip-flops; hresp tied to OKAY, busy_out decoded from state_reg
    assign hrdata_out = rdata_reg;
    assign hreadyout_out = hready_reg;
    assign hresp_out = 1'b0;       // Always OKAY
    assign irq_out = irq_reg;
    assign fault_indicator_out = fault_reg;
    assign busy_out = (state_reg == bdm_pkg::ST_RUN); // Bit run in progress

endmodule

`default_nettype wire

/* design/bdm_pkg.sv */
// Package for the bit and digit move unit: register map, field layout,
// reset values and state encoding.
// Assumes one 20 MHz clock and a single AHB-Lite master.
package bdm_pkg;

    // ==================================================================
    // Sizes
    localparam int unsigned WORD_W = 16;
    localparam int unsigned DATA_WORDS = 32;
    localparam int unsigned IDX_W = 5;
    localparam int unsigned ADDR_W = 12;

    // ==================================================================
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CW = 12'h004;
    localparam logic [11:0] OFS_SRC = 12'h008;
    localparam logic [11:0] OFS_DST = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_IRQ_STS = 12'h014;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h018;
    // Data area words sit at 0x100 + 4*index, index 0..31
    localparam logic [4:0] DATA_PAGE = 5'h02;

    // ==================================================================
    // Field positions
    localparam int unsigned CTRL_SINGLE_BIT = 0;
    localparam int unsigned CTRL_NIBBLE_BIT = 1;
    localparam int unsigned CTRL_RUN_BIT = 2;
    localparam int unsigned STS_FAULT_BIT = 0;
    localparam int unsigned STS_BUSY_BIT = 1;
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_FAULT_BIT = 1;

    // ==================================================================
    // Reset values and digit limit
    localparam logic [15:0] CW_RESET = 16'h0000;
    localparam logic [4:0] IDX_RESET = 5'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [3:0] NIBBLE_MAX = 4'h3;

    // ==================================================================
    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } bdm_state_type;

endpackage

/* design/bdm_word_ops.sv */
// Single-word operations: one-bit copy and nibble copy with wrap-around.
// Purely combinational; the caller registers result and error.
`timescale 1ns/1ps
`default_nettype none

module bdm_word_ops (
    input wire logic [15:0] src_word_in,
    input wire logic [15:0] dst_word_in,
    input wire logic [15:0] ctrl_word_in,
    input wire logic nibble_mode_in,
    output logic [15:0] result_out,
    output logic error_out
);

    logic [3:0] src_sel;
    logic [3:0] cnt_m1;
    logic [3:0] dst_sel;
    logic [15:0] bit_res;
    logic [15:0] nib_res;
    logic bit_err;
    logic nib_err;

    // ==================================================================
    // Field split: low nibble selects source, next nibble count less one, third nibble destination
    assign src_sel = ctrl_word_in[3:0];
    assign cnt_m1 = ctrl_word_in[7:4];
    assign dst_sel = ctrl_word_in[11:8];

    // Both bytes must name a bit 0..15
    assign bit_err = (ctrl_word_in[7:4] != 4'h0) || (ctrl_word_in[15:12] != 4'h0);

    // Any of the three low nibbles above 3 is illegal
    assign nib_err = (src_sel > bdm_pkg::NIBBLE_MAX) || (cnt_m1 > bdm_pkg::NIBBLE_MAX) ||
                     (dst_sel > bdm_pkg::NIBBLE_MAX);

    // Copy one bit; everything else passes through, so S equal to D works
    always_comb begin
        bit_res = dst_word_in;
        bit_res[dst_sel] = src_word_in[src_sel];
    end

    // Copy count nibbles, both indices wrapping modulo four
    always_comb begin
        logic [1:0] s_dig;
        logic [1:0] d_dig;
        s_dig = 2'h0;
        d_dig = 2'h0;
        nib_res = dst_word_in;
        for (int i = 0; i < 4; i++) begin
            s_dig = 2'(src_sel[1:0] + 2'(i));
            d_dig = 2'(dst_sel[1:0] + 2'(i));
            if (3'(i) <= cnt_m1[2:0]) begin
                nib_res[{d_dig, 2'b00} +: 4] = src_word_in[{s_dig, 2'b00} +: 4];
            end
        end
    end

    // On a bad control word the destination is left alone
    assign result_out = nibble_mode_in ? (nib_err ? dst_word_in : nib_res) :
                        (bit_err ? dst_word_in : bit_res);
    assign error_out = nibble_mode_in ? nib_err : bit_err;

endmodule

`default_nettype wire

/* verif/bdm_move_unit_chk.sv */
// Checker for the bit and digit move unit: bus timing, run length, flags.
// Sees only top-level ports; bound into every bdm_move_unit below.
`timescale 1ns/1ps
`default_nettype none

module bdm_move_chk (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic fault_indicator_out,
    input wire logic busy_out
);
    // ==================================================================
    // Helper state
    logic take;
    logic rd1_reg, rd2_reg, cmd_reg, cwp_reg;
    logic [7:0] cnt_reg;
    logic [8:0] bcnt_reg, since_reg;
    assign take = hsel_in & htrans_in[1] & hready_in;
    // Data phase flags, last run count written, busy length, age of last command
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd1_reg <= 1'b0;
            rd2_reg <= 1'b0;
            cmd_reg <= 1'b0;
            cwp_reg <= 1'b0;
            cnt_reg <= 8'h00;
            bcnt_reg <= 9'h000;
            since_reg <= 9'h1FF;
        end else begin
            rd1_reg <= take & ~hwrite_in;
            rd2_reg <= rd1_reg;
            cmd_reg <= take & hwrite_in & (haddr_in[11:0] == 12'h000);
            cwp_reg <= take & hwrite_in & (haddr_in[11:0] == 12'h004);
            cnt_reg <= cwp_reg ? hwdata_in[15:8] : cnt_reg;
            bcnt_reg <= busy_out ? bcnt_reg + 9'h001 : 9'h000;
            // Saturates so an old command never looks recent again
            since_reg <= cmd_reg ? 9'h000 : ((since_reg == 9'h1FF) ? since_reg : since_reg + 9'h001);
        end
    end

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    resp_okay_a: assert property (hresp_out == 1'b0) else $error("response not OKAY");
    read_wait_a: assert property (take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    write_nowait_a: assert property (take && hwrite_in |=> hreadyout_out) else $error("write stalled");
    wait_cause_a: assert property (!hreadyout_out |-> rd1_reg) else $error("stall outside read");
    rdata_hold_a: assert property ($changed(hrdata_out) |-> rd1_reg || rd2_reg) else $error("read data moved");
    run_length_a: assert property ($fell(busy_out) |-> bcnt_reg == {1'b0, cnt_reg})
        else $error("run length differs from count");
    run_bound_a: assert property (busy_out |-> bcnt_reg < 9'd255) else $error("run too long");
    busy_cause_a: assert property ($rose(busy_out) |-> since_reg <= 9'd3)
        else $error("run without command");
    fault_cause_a: assert property ($changed(fault_indicator_out) |-> since_reg < 9'd300)
        else $error("fault moved without command");
    run_fault_a: assert property ($fell(busy_out) |-> !fault_indicator_out)
        else $error("fault set after run");
    run_done_c: cover property ($fell(busy_out));
    read_c: cover property (rd2_reg && hreadyout_out);
    fault_c: cover property ($rose(fault_indicator_out));
endmodule

bind bdm_move_unit bdm_move_chk chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .fault_indicator_out(fault_indicator_out), .busy_out(busy_out));
`default_nettype wire

/* verif/bdm_ahb_master.sv */
// Sequencer stand-in: single-word AHB-Lite master with bounded waits.
// Caller enters each task right after a rising edge; lapsed waits counted.
`timescale 1ns/1ps
`default_nettype none

module bdm_ahb_master (
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output var logic hsel_out,
    output var logic [31:0] haddr_out,
    output var logic [1:0] htrans_out,
    output var logic hwrite_out,
    output var logic [2:0] hsize_out,
    output var logic [31:0] hwdata_out,
    output var logic [7:0] tmo_out
);
    // Idle bus at time zero; word size only
    initial begin
        hsel_out = 1'b1;
        haddr_out = 32'h0000_0000;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h0000_0000;
        tmo_out = 8'h00;
    end
    // Hold the phase until hready is sampled high at an edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (hready_in !== 1'b1 && n < 16);
        if (hready_in !== 1'b1) tmo_out <= tmo_out + 8'h01;
    endtask
    // Commands start only through a CTRL write, never while one runs
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        htrans_out <= 2'h2;
        haddr_out <= a;
        hwrite_out <= 1'b1;
        wait_ready;
        htrans_out <= 2'h0;
        hwdata_out <= d;
        wait_ready;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        htrans_out <= 2'h2;
        haddr_out <= a;
        hwrite_out <= 1'b0;
        wait_ready;
        htrans_out <= 2'h0;
        wait_ready;
        d = hrdata_in;
    endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench: bus master model drives the unit, integer model
// predicts every data word, flag and interrupt. One clock, one reset.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk_in, arst_n_in, hsel, hwrite, hready, hresp, irq, fault, busy;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] tmo;
    int err_count, checks_done, seed, fault_m, i, k, c, s, stuck;
    int mem[32];
    int rst_a[8] = '{'h000, 'h004, 'h008, 'h00C, 'h010, 'h014, 'h018, 'h020};
    // Rows: kind, control word, source, destination, irq mask, poke while busy
    int tab[15][6] = '{'{1, 'h0C05, 3, 7, 1, 0}, '{7, 'h0F00, 5, 5, 1, 0}, '{1, 'h1005, 2, 6, 2, 0},
        '{1, 'h0010, 2, 6, 0, 0}, '{2, 'h0031, 1, 2, 3, 0}, '{6, 'h0123, 4, 9, 0, 0},
        '{2, 'h0004, 4, 9, 2, 0}, '{2, 'h0040, 4, 9, 0, 0}, '{2, 'h0400, 4, 9, 0, 0},
        '{4, 'h0000, 0, 1, 1, 0}, '{4, 'h1406, 0, 8, 0, 0}, '{4, 'h0A40, 2, 2, 0, 0},
        '{4, 'h0A04, 2, 2, 0, 0}, '{4, 'hFF3C, 1, 3, 1, 1}, '{0, 'h0C05, 3, 7, 1, 0}};

    bdm_ahb_master mst_u (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
        .hwdata_out(hwdata), .tmo_out(tmo));
    bdm_move_unit dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .irq_out(irq),
        .fault_indicator_out(fault), .busy_out(busy));

    // ==================================================================
    // Clock, checks and verdict
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        err_count += tmo;
        $display("TB: %0d checks, %0d mismatches", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==================================================================
    // Model: source snapshot first, so overlapping ranges copy cleanly
    function automatic void model(input int kd, input int cw, input int sw, input int dw);
        int src[32];
        int b, g, n;
        src = mem;
        if (kd % 2 == 1) begin
            fault_m = (cw[7:4] != 0 || cw[15:12] != 0);
            if (fault_m == 0) mem[dw][cw[11:8]] = src[sw][cw[3:0]];
        end else if (kd % 4 >= 2) begin
            fault_m = (cw[3:0] > 3 || cw[7:4] > 3 || cw[11:8] > 3);
            for (b = 0; b <= cw[7:4] && fault_m == 0; b++) begin
                for (g = 0; g < 4; g++) mem[dw][(cw[11:8] + b) % 4 * 4 + g] = src[sw][(cw[3:0] + b) % 4 * 4 + g];
            end
        end else if (kd >= 4) begin
            fault_m = 0;
            for (b = 0; b < cw[15:8]; b++) begin
                n = sw * 16 + cw[3:0] + b;
                g = dw * 16 + cw[7:4] + b;
                mem[g / 16 % 32][g % 16] = src[n / 16 % 32][n % 16];
            end
        end
    endfunction
    // One command, then flags, interrupt and the whole data area compared
    task automatic do_op(input int kd, input int cw, input int sw, input int dw, input int m, input int pk);
        int n, sts;
        mst_u.wr(32'h018, m);
        mst_u.wr(32'h004, cw);
        mst_u.wr(32'h008, sw);
        mst_u.wr(32'h00C, dw);
        mst_u.wr(32'h000, kd);
        if (pk != 0) mst_u.wr(32'h17C, ~mem[31]);
        model(kd, cw, sw, dw);
        sts = (kd != 0) ? 1 + 2 * fault_m : 0;
        n = 0;
        do begin
            mst_u.rd(32'h010, v);
            n++;
        end while (v[1] !== 1'b0 && n < 200);
        chk("status", fault_m, v);
        if (v[1] !== 1'b0) stuck = 1; // Poll limit used up: end the run
        chk("fault pin", fault_m, fault);
        chk("irq pin", (sts & m) != 0, irq);
        mst_u.rd(32'h014, v);
        chk("irq status", sts, v);
        mst_u.wr(32'h014, 32'h3);
        mst_u.rd(32'h014, v);
        chk("irq cleared", 0, v);
        chk("irq pin low", 0, irq);
        for (n = 0; n < 32; n++) begin
            mst_u.rd(32'h100 + 4 * n, v);
            chk("data word", mem[n], v);
        end
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        arst_n_in = 1'b0;
        err_count = 0;
        checks_done = 0;
        seed = 73402;
        repeat (12) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("pins after reset", 0, {irq, fault, busy});
        mst_u.wr(32'h020, 32'hFFFF);
        foreach (rst_a[j]) begin
            mst_u.rd(rst_a[j], v);
            chk("reset value", 0, v);
        end
        for (i = 0; i < 32; i++) begin
            mem[i] = $random(seed) & 'hFFFF;
            mst_u.wr(32'h100 + 4 * i, mem[i]);
        end
        $display("TB: reset and load test done");
        for (i = 0; i < 15; i++) begin
            do_op(tab[i][0], tab[i][1], tab[i][2], tab[i][3], tab[i][4], tab[i][5]);
        end
        $display("TB: directed test done");
        // Random legal commands; ranges kept inside the data area
        for (i = 0; i < 12; i++) begin
            k = 1 << ($unsigned($random(seed)) % 3);
            c = $random(seed) & 'hFFFF;
            if (k == 1) c &= 'h0F0F;
            if (k == 2) c &= 'h0333;
            s = $unsigned($random(seed)) % 16;
            do_op(k, c, s, (s + 1 + $unsigned($random(seed)) % 15) % 16, $random(seed) & 3, 0);
        end
        $display("TB: random test done");
        end_of_test;
    end
    // Overall bound on the run; a lapsed bus or poll wait ends it early
    initial begin
        repeat (90000) begin
            @(posedge clk_in);
            if (tmo != 8'h00 || stuck != 0) break;
        end
        err_count++;
        end_of_test;
    end
endmodule
`default_nettype wire
